// ==== core/ssi_pkg.sv ====
// Shared constants and types for the serial SRAM bus slave
package ssi_pkg;
	localparam int        ADDR_W      = 11;      // Array address width, 2048 bytes
	localparam int        DEPTH       = 2048;    // Array depth in bytes
	localparam int        BIT_ACK     = 8;       // Bit count value of the acknowledge slot
	localparam int        BIT_LAST    = 7;       // Bit count value of the last data bit
	localparam logic [3:0] CNT_START  = 4'hF;    // Bit count after Start, its clock fall wraps to zero
	localparam logic [3:0] OP_SRAM    = 4'hA;    // Op code selecting the array
	localparam logic [3:0] OP_REG     = 4'h3;    // Op code selecting the control registers
	localparam logic [7:0] REG_STATUS = 8'h00;   // Configuration and flags register address
	localparam logic [7:0] REG_CMD    = 8'h55;   // Store and recall trigger register address
	localparam logic [7:0] CMD_STORE  = 8'h33;   // Software store command value
	localparam logic [7:0] CMD_RECALL = 8'hDD;   // Software recall command value
	localparam logic [4:0] CFG_RST    = 5'h00;   // Reset value of protect, auto store, event
	localparam int        POS_AM      = 7;       // Array modified flag position
	localparam int        POS_BP      = 2;       // Lowest protect range bit position
	localparam int        POS_ASE     = 1;       // Auto store enable position
	localparam int        PROT_BASE   = 4;       // One below log2 of the smallest protected block
	localparam logic [2:0] SYNC_RST   = 3'h7;    // Synchroniser reset level, bus idle high

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_CTRL,
		ST_ADDR_HI,
		ST_ADDR_LO,
		ST_REG_ADDR,
		ST_WDATA,
		ST_RDATA
	} ssi_state_type;
endpackage

// ==== core/ssi_sync.sv ====
// Three stage input synchroniser with agreement filter
module ssi_sync #(
	parameter int W = 4
) (
	input  wire logic         clk,   // System clock
	input  wire logic         rst,   // Synchronous reset, active high
	input  wire logic         ce,    // Clock enable
	input  wire logic [W-1:0] d,     // Asynchronous inputs
	output logic      [W-1:0] q      // Filtered synchronous outputs
);
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic [2:0] s_r;
			logic [2:0] s_nxt;
			logic       q_r;
			logic       q_nxt;
			// Shift chain and accept a level when stages two and three agree
			always_comb begin
				s_nxt = {s_r[1:0], d[i]};
				q_nxt = (s_r[1] == s_r[2]) ? s_r[2] : q_r;
			end
			always_ff @(posedge clk) begin
				if (rst) begin
					s_r <= ssi_pkg::SYNC_RST;
					q_r <= 1'b1;
				end else if (ce) begin
					s_r <= s_nxt;
					q_r <= q_nxt;
				end
			end
			assign q[i] = q_r;
		end
	endgenerate
endmodule

// ==== core/ssi_mem.sv ====
// Byte array with one write port and a registered read port
module ssi_mem (
	input  wire logic                      clk,    // System clock
	input  wire logic                      ce,     // Clock enable
	input  wire logic                      we,     // Write strobe
	input  wire logic [ssi_pkg::ADDR_W-1:0] addr,  // Read and write address
	input  wire logic [7:0]                wdata,  // Write data
	output logic      [7:0]                rdata   // Registered read data
);
	logic [7:0] mem [ssi_pkg::DEPTH];
	logic [7:0] rdata_nxt;

	// Read data follows the address one cycle later
	always_comb begin
		rdata_nxt = mem[addr];
	end
	always_ff @(posedge clk) begin
		if (ce) begin
			if (we) begin
				mem[addr] <= wdata;
			end
			rdata <= rdata_nxt;
		end
	end
endmodule

// ==== core/ssi_slave.sv ====
// Two wire bus slave front end for the battery backed byte array
// Notes on behaviour
// - Op code A selects the array, op code 3 the control registers.
// - Answer only when both select bits match the pins and fixed bit is zero.
// - After array write control, two bytes load the pointer, high first.
// - Each written byte is committed at the rising clock of its acknowledge.
// - On abort, acknowledged bytes stay; an uncommitted final byte is dropped.
// - Protected target: no acknowledge, pointer kept, bus ignored until Start.
// - After a single write the pointer holds the following location.
// - Sequential writes store and acknowledge every unprotected byte, pointer plus one.
// - Pointer wraps from the last location to zero and continues.
// - An array read starts at the current pointer, no address bytes.
// - Master acknowledge low asks for the next byte, high ends the read.
// - Read control byte is acknowledged, then one byte is shifted out.
// - Repeated Start after address keeps the loaded pointer, drops the write.
// - Pointer advances after every array byte read or written.
// - A store starting during any access aborts that access.
// - Register 00h is configuration and flags; 55h takes writes only.
// - An undefined register address gets no acknowledge, nor its data.
// - Protect code guards an upper fraction; code 1 guards the top 1/64.
module ssi_slave (
	input  wire logic CLK_SYS,             // System clock, 250 MHz
	input  wire logic RST,                 // Synchronous reset, active high
	input  wire logic CE,                  // Clock enable, freezes all state when low
	input  wire logic SCL,                 // Bus clock pin
	input  wire logic SDA_I,               // Bus data pin level
	output logic      SDA_O,               // Bus data drive level, always low
	output logic      SDA_OE,              // Bus data pull down enable
	input  wire logic SELECT_PIN_HIGH,     // Upper chip select strap
	input  wire logic SELECT_PIN_LOW,      // Lower chip select strap
	input  wire logic STORE_START,         // Automatic or pin store begins, pulse
	input  wire logic STORE_DONE,          // Store or recall finished, pulse
	output logic      SW_STORE,            // Software store command, pulse
	output logic      SW_RECALL,           // Software recall command, pulse
	output logic      AUTO_STORE_ENABLE,   // Auto store enable setting
	output logic      ARRAY_MODIFIED_FLAG  // Array written since last store or recall
);
	localparam int AW = ssi_pkg::ADDR_W;

	logic [3:0]                 pins_s;
	logic                       scl_s, sda_s;
	logic                       scl_q_r, sda_q_r;
	logic                       scl_rise, scl_fall;
	logic                       bus_start, bus_stop;
	ssi_pkg::ssi_state_type     st_r, st_nxt;
	logic [3:0]                 cnt_r, cnt_nxt;
	logic [7:0]                 sh_r, sh_nxt;
	logic [7:0]                 tx_r, tx_nxt;
	logic                       oe_r, oe_nxt;
	logic [AW-1:0]              ptr_r, ptr_nxt;
	logic [7:0]                 hi_r, hi_nxt;
	logic                       sram_r, sram_nxt;
	logic                       rw_r, rw_nxt;
	logic                       selcmd_r, selcmd_nxt;
	logic                       mack_r, mack_nxt;
	logic [4:0]                 cfg_r, cfg_nxt;
	logic                       am_r, am_nxt;
	logic                       sws_r, sws_nxt;
	logic                       swr_r, swr_nxt;
	logic                       mem_we, ctrl_ok, prot;
	logic [7:0]                 mem_rdata, status, rd_byte;
	logic [AW-1:0]              low_mask;
	logic [2:0]                 bp;

	// Pins pass four flip-flops before use
	ssi_sync #(.W(4)) u_sync (
		.clk (CLK_SYS),
		.rst (RST),
		.ce  (CE),
		.d   ({SCL, SDA_I, SELECT_PIN_HIGH, SELECT_PIN_LOW}),
		.q   (pins_s)
	);

	ssi_mem u_mem (
		.clk   (CLK_SYS),
		.ce    (CE),
		.we    (mem_we),
		.addr  (ptr_r),
		.wdata (sh_r),
		.rdata (mem_rdata)
	);

	// Bus edge and condition detection on filtered levels
	assign scl_s     = pins_s[3];
	assign sda_s     = pins_s[2];
	assign scl_rise  = CE && scl_s && !scl_q_r;
	assign scl_fall  = CE && !scl_s && scl_q_r;
	assign bus_start = CE && scl_s && scl_q_r && sda_q_r && !sda_s;
	assign bus_stop  = CE && scl_s && scl_q_r && !sda_q_r && sda_s;

	// Control byte decode and write protection check
	assign ctrl_ok  = (sh_r[7:4] == ssi_pkg::OP_SRAM || sh_r[7:4] == ssi_pkg::OP_REG)
			&& sh_r[3:2] == pins_s[1:0] && !sh_r[1];
	assign bp       = cfg_r[ssi_pkg::POS_BP +: 3];
	assign low_mask = AW'((12'h001 << (ssi_pkg::PROT_BASE + 32'(bp))) - 12'h001);
	assign prot     = (bp != 3'h0) && ((ptr_r | low_mask) == {AW{1'b1}});
	assign status   = {am_r, 2'b00, cfg_r};
	assign rd_byte  = sram_r ? mem_rdata : (selcmd_r ? 8'h00 : status);

	// Protocol sequencer next state
	always_comb begin
		st_nxt     = st_r;
		cnt_nxt    = cnt_r;
		sh_nxt     = sh_r;
		tx_nxt     = tx_r;
		oe_nxt     = oe_r;
		ptr_nxt    = ptr_r;
		hi_nxt     = hi_r;
		sram_nxt   = sram_r;
		rw_nxt     = rw_r;
		selcmd_nxt = selcmd_r;
		mack_nxt   = mack_r;
		cfg_nxt    = cfg_r;
		am_nxt     = am_r && !(STORE_DONE && CE); // Finished store clears, a write below wins
		sws_nxt    = 1'b0;
		swr_nxt    = 1'b0;
		mem_we     = 1'b0;
		if (CE && STORE_START) begin
			st_nxt  = ssi_pkg::ST_IDLE;
			oe_nxt  = 1'b0;
			cnt_nxt = 4'h0;
		end else if (bus_start) begin
			st_nxt  = ssi_pkg::ST_CTRL;
			oe_nxt  = 1'b0;
			cnt_nxt = ssi_pkg::CNT_START;                  // Start clock fall is not a bit
		end else if (bus_stop) begin
			st_nxt  = ssi_pkg::ST_IDLE;
			oe_nxt  = 1'b0;
		end else if (st_r != ssi_pkg::ST_IDLE) begin
			if (scl_rise) begin
				if (cnt_r < 4'(ssi_pkg::BIT_ACK)) begin
					sh_nxt = {sh_r[6:0], sda_s};
				end else begin
					case (st_r)
						ssi_pkg::ST_ADDR_LO: begin
							ptr_nxt = {hi_r[AW-9:0], sh_r};
						end
						ssi_pkg::ST_WDATA: begin
							if (sram_r) begin
								mem_we  = 1'b1;
								ptr_nxt = ptr_r + 1'b1;
								am_nxt  = 1'b1;
							end else if (!selcmd_r) begin
								cfg_nxt = sh_r[4:0];
							end else begin
								sws_nxt = (sh_r == ssi_pkg::CMD_STORE);
								swr_nxt = (sh_r == ssi_pkg::CMD_RECALL);
							end
						end
						ssi_pkg::ST_RDATA: begin
							if (!oe_r) begin
								mack_nxt = !sda_s;
								if (sram_r) begin
									ptr_nxt = ptr_r + 1'b1;
								end
							end
						end
						default: begin
						end
					endcase
				end
			end
			if (scl_fall) begin
				if (cnt_r == 4'(ssi_pkg::BIT_LAST)) begin
					cnt_nxt = 4'(ssi_pkg::BIT_ACK);
					oe_nxt  = 1'b1;
					case (st_r)
						ssi_pkg::ST_CTRL: begin
							sram_nxt = (sh_r[7:4] == ssi_pkg::OP_SRAM);
							rw_nxt   = sh_r[0];
							mack_nxt = 1'b1;
							if (!ctrl_ok) begin
								st_nxt = ssi_pkg::ST_IDLE;
								oe_nxt = 1'b0;
							end
						end
						ssi_pkg::ST_ADDR_HI: begin
							hi_nxt = sh_r;
						end
						ssi_pkg::ST_REG_ADDR: begin
							selcmd_nxt = (sh_r == ssi_pkg::REG_CMD);
							if (sh_r != ssi_pkg::REG_STATUS && sh_r != ssi_pkg::REG_CMD) begin
								st_nxt = ssi_pkg::ST_IDLE;
								oe_nxt = 1'b0;
							end
						end
						ssi_pkg::ST_WDATA: begin
							if ((sram_r && prot) || (!sram_r && selcmd_r
									&& sh_r != ssi_pkg::CMD_STORE
									&& sh_r != ssi_pkg::CMD_RECALL)) begin
								st_nxt = ssi_pkg::ST_IDLE;
								oe_nxt = 1'b0;
							end
						end
						ssi_pkg::ST_RDATA: begin
							oe_nxt = 1'b0;
						end
						default: begin
						end
					endcase
				end else if (cnt_r == 4'(ssi_pkg::BIT_ACK)) begin
					cnt_nxt = 4'h0;
					oe_nxt  = 1'b0;
					case (st_r)
						ssi_pkg::ST_CTRL: begin
							if (rw_r) begin
								st_nxt = ssi_pkg::ST_RDATA;
								tx_nxt = rd_byte;
								oe_nxt = !rd_byte[7];
							end else if (sram_r) begin
								st_nxt = ssi_pkg::ST_ADDR_HI;
							end else begin
								st_nxt = ssi_pkg::ST_REG_ADDR;
							end
						end
						ssi_pkg::ST_ADDR_HI: begin
							st_nxt = ssi_pkg::ST_ADDR_LO;
						end
						ssi_pkg::ST_ADDR_LO, ssi_pkg::ST_REG_ADDR: begin
							st_nxt = ssi_pkg::ST_WDATA;
						end
						ssi_pkg::ST_RDATA: begin
							if (mack_r) begin
								tx_nxt = rd_byte;
								oe_nxt = !rd_byte[7];
							end else begin
								st_nxt = ssi_pkg::ST_IDLE;
							end
						end
						default: begin
						end
					endcase
				end else begin
					cnt_nxt = cnt_r + 4'h1;
					if (st_r == ssi_pkg::ST_RDATA) begin
						tx_nxt = {tx_r[6:0], 1'b0};
						oe_nxt = !tx_r[6];
					end
				end
			end
		end
	end

	// Sequencer registers
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			st_r     <= ssi_pkg::ST_IDLE;
			cnt_r    <= 4'h0;
			sh_r     <= 8'h00;
			tx_r     <= 8'h00;
			oe_r     <= 1'b0;
			ptr_r    <= '0;
			hi_r     <= 8'h00;
			sram_r   <= 1'b0;
			rw_r     <= 1'b0;
			selcmd_r <= 1'b0;
			mack_r   <= 1'b0;
			cfg_r    <= ssi_pkg::CFG_RST;
			am_r     <= 1'b0;
			sws_r    <= 1'b0;
			swr_r    <= 1'b0;
			scl_q_r  <= 1'b1;
			sda_q_r  <= 1'b1;
		end else if (CE) begin
			st_r     <= st_nxt;
			cnt_r    <= cnt_nxt;
			sh_r     <= sh_nxt;
			tx_r     <= tx_nxt;
			oe_r     <= oe_nxt;
			ptr_r    <= ptr_nxt;
			hi_r     <= hi_nxt;
			sram_r   <= sram_nxt;
			rw_r     <= rw_nxt;
			selcmd_r <= selcmd_nxt;
			mack_r   <= mack_nxt;
			cfg_r    <= cfg_nxt;
			am_r     <= am_nxt;
			sws_r    <= sws_nxt;
			swr_r    <= swr_nxt;
			scl_q_r  <= scl_s;
			sda_q_r  <= sda_s;
		end
	end

	// Outputs
	assign SDA_O               = 1'b0;
	assign SDA_OE              = oe_r;
	assign SW_STORE            = sws_r;
	assign SW_RECALL           = swr_r;
	assign AUTO_STORE_ENABLE   = cfg_r[ssi_pkg::POS_ASE];
	assign ARRAY_MODIFIED_FLAG = am_r;

	// Checks on the sequencer
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RST);

	sequence s_byte_end;
		scl_fall && cnt_r == 4'h7 && !STORE_START && !bus_start && !bus_stop;
	endsequence
	property p_bad_ctrl;
		s_byte_end and (st_r == ssi_pkg::ST_CTRL && !ctrl_ok) |=> !oe_r && st_r == ssi_pkg::ST_IDLE;
	endproperty
	a_bad_ctrl: assert property (p_bad_ctrl) else $error("bad control byte acknowledged");
	property p_addr_load;
		(scl_rise && st_r == ssi_pkg::ST_ADDR_LO && cnt_r == 4'h8 && !STORE_START
			&& !bus_start && !bus_stop) |=> ptr_r == {$past(hi_r[AW-9:0]), $past(sh_r)};
	endproperty
	a_addr_load: assert property (p_addr_load) else $error("pointer not loaded");
	property p_commit_edge;
		mem_we |-> scl_rise && cnt_r == 4'h8 && st_r == ssi_pkg::ST_WDATA;
	endproperty
	a_commit_edge: assert property (p_commit_edge) else $error("write outside ack rise");
	property p_protect;
		s_byte_end and (st_r == ssi_pkg::ST_WDATA && sram_r && prot)
			|=> !oe_r && st_r == ssi_pkg::ST_IDLE && $stable(ptr_r);
	endproperty
	a_protect: assert property (p_protect) else $error("protected write acknowledged");
	property p_advance;
		mem_we |=> ptr_r == AW'($past(ptr_r) + 1'b1) && am_r;
	endproperty
	a_advance: assert property (p_advance) else $error("pointer did not advance");
	property p_store_abort;
		(CE && STORE_START) |=> st_r == ssi_pkg::ST_IDLE && !oe_r ##1 !mem_we;
	endproperty
	a_store_abort: assert property (p_store_abort) else $error("store did not abort");
	property p_bad_reg;
		s_byte_end and (st_r == ssi_pkg::ST_REG_ADDR && sh_r != ssi_pkg::REG_STATUS
			&& sh_r != ssi_pkg::REG_CMD) |=> st_r == ssi_pkg::ST_IDLE && !oe_r;
	endproperty
	a_bad_reg: assert property (p_bad_reg) else $error("undefined register acknowledged");
	property p_read_end;
		(scl_fall && st_r == ssi_pkg::ST_RDATA && cnt_r == 4'h8 && !mack_r && !STORE_START
			&& !bus_start && !bus_stop) |=> st_r == ssi_pkg::ST_IDLE && !oe_r;
	endproperty
	a_read_end: assert property (p_read_end) else $error("read not ended");
	property p_ctrl_ack;
		s_byte_end and (st_r == ssi_pkg::ST_CTRL && ctrl_ok) |=> oe_r && cnt_r == 4'h8;
	endproperty
	a_ctrl_ack: assert property (p_ctrl_ack) else $error("valid control not acknowledged");
endmodule

// ==== tb/ssi_mst.sv ====
// Bus master model that builds clock and data from the link clock
module ssi_mst (
	input  wire logic clk_link,  // Link clock, each edge is one step
	input  wire logic sda,       // Resolved data line level
	output logic      scl,       // Bus clock drive, still outside frames
	output logic      sda_drv    // Data drive, high releases to pull-up
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle bus, both lines high
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end

	// One bit: data set with clock low, sampled as the clock falls
	task automatic bit_x(input logic b, output logic s);
		@(clk_link) sda_drv <= b;
		@(clk_link) scl <= 1'b1;
		@(clk_link) s = sda;
		scl <= 1'b0;
	endtask

	// Start from idle, or repeated Start with the clock low
	task automatic start();
		@(clk_link) sda_drv <= 1'b1;
		@(clk_link) scl <= 1'b1;
		@(clk_link) sda_drv <= 1'b0;
		@(clk_link) scl <= 1'b0;
	endtask

	// Stop: data rises while the clock is high
	task automatic stop();
		@(clk_link) sda_drv <= 1'b0;
		@(clk_link) scl <= 1'b1;
		@(clk_link) sda_drv <= 1'b1;
	endtask

	// Byte out MSB first, returns the device acknowledge
	task automatic wr(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], s);
		end
		bit_x(1'b1, s);
		ack = ~s;
	endtask

	// Byte in, then acknowledge low or released on the last byte
	task automatic rd(input logic last, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_x(1'b1, s);
			d[i] = s;
		end
		bit_x(last, s);
	endtask
endmodule

// ==== tb/tb.sv ====
// Self-checking bench for the bus slave driven by the master model
module tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic       CLK_SYS, RST, CE, SCL, SDA_I, SDA_O, SDA_OE;
	logic       SELECT_PIN_HIGH, SELECT_PIN_LOW, STORE_START, STORE_DONE;
	logic       SW_STORE, SW_RECALL, AUTO_STORE_ENABLE, ARRAY_MODIFIED_FLAG;
	logic       clk_link, m_sda;
	logic [7:0] n_store, n_recall;
	int         n_mismatch, checked;

	// Control bytes for straps high=1 low=0
	localparam logic [7:0] C_AW = 8'hA8;
	localparam logic [7:0] C_AR = 8'hA9;
	localparam logic [7:0] C_RW = 8'h38;
	localparam logic [7:0] C_RR = 8'h39;
	localparam logic [7:0] BAD [4] = '{8'hA0, 8'hAC, 8'hAA, 8'h58};

	ssi_slave i_dut (
		.CLK_SYS(CLK_SYS), .RST(RST), .CE(CE), .SCL(SCL), .SDA_I(SDA_I),
		.SDA_O(SDA_O), .SDA_OE(SDA_OE), .SELECT_PIN_HIGH(SELECT_PIN_HIGH),
		.SELECT_PIN_LOW(SELECT_PIN_LOW), .STORE_START(STORE_START),
		.STORE_DONE(STORE_DONE), .SW_STORE(SW_STORE), .SW_RECALL(SW_RECALL),
		.AUTO_STORE_ENABLE(AUTO_STORE_ENABLE),
		.ARRAY_MODIFIED_FLAG(ARRAY_MODIFIED_FLAG)
	);
	ssi_mst i_mst (.clk_link(clk_link), .sda(SDA_I), .scl(SCL), .sda_drv(m_sda));

	// Open drain data line with pull-up
	assign SDA_I = m_sda & ~SDA_OE;

	// System clock, 4 ns
	initial begin
		CLK_SYS = 1'b0;
		forever #2 CLK_SYS = ~CLK_SYS;
	end

	// Link clock, 160 ns, offset phase
	initial begin
		clk_link = 1'b0;
		#13;
		forever #80 clk_link = ~clk_link;
	end

	// Count command pulses
	always @(posedge CLK_SYS) begin
		if (RST) begin
			n_store <= 8'h00;
			n_recall <= 8'h00;
		end else begin
			n_store <= n_store + {7'h00, SW_STORE};
			n_recall <= n_recall + {7'h00, SW_RECALL};
		end
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wrb(input logic [7:0] d, input logic exp_ack);
		logic a;
		i_mst.wr(d, a);
		check({7'h00, a}, {7'h00, exp_ack});
	endtask

	task automatic rdb(input logic last, input logic [7:0] exp);
		logic [7:0] d;
		i_mst.rd(last, d);
		check(d, exp);
	endtask

	task automatic set_ptr(input logic [15:0] a);
		i_mst.start();
		wrb(C_AW, 1'b1);
		wrb(a[15:8], 1'b1);
		wrb(a[7:0], 1'b1);
	endtask

	task automatic cur_read(input logic [7:0] exp);
		i_mst.start();
		wrb(C_AR, 1'b1);
		rdb(1'b1, exp);
		i_mst.stop();
	endtask

	task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
		i_mst.start();
		wrb(C_RW, 1'b1);
		wrb(a, 1'b1);
		i_mst.start();
		wrb(C_RR, 1'b1);
		rdb(1'b1, exp);
		i_mst.stop();
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d, input logic ka, input logic kd);
		i_mst.start();
		wrb(C_RW, 1'b1);
		wrb(a, ka);
		wrb(d, kd);
		i_mst.stop();
	endtask

	task automatic report_and_stop();
		$display("counts: %0d checks, %0d mismatches", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Watchdog, tests take about 50k cycles
	initial begin
		repeat (95000) @(posedge CLK_SYS);
		n_mismatch++;
		report_and_stop();
	end

	// Main test sequence
	initial begin
		RST = 1'b1;
		CE = 1'b1;
		SELECT_PIN_HIGH = 1'b1;
		SELECT_PIN_LOW = 1'b0;
		STORE_START = 1'b0;
		STORE_DONE = 1'b0;
		n_mismatch = 0;
		checked = 0;
		repeat (2) @(posedge CLK_SYS);
		RST <= 1'b0;
		repeat (8) @(posedge CLK_SYS);
		// Reset state
		rd_reg(8'h00, 8'h00);
		check({7'h00, ARRAY_MODIFIED_FLAG}, 8'h00);
		check({7'h00, SDA_O}, 8'h00);
		$display("test reset done");
		// Sequential write across the top, then single write and reads
		set_ptr(16'hFFFE);
		for (int i = 0; i < 4; i++) begin
			wrb(8'(8'h11 * (i + 1)), 1'b1);
		end
		i_mst.stop();
		check({7'h00, ARRAY_MODIFIED_FLAG}, 8'h01);
		set_ptr(16'h07FD);
		wrb(8'h5A, 1'b1);
		i_mst.stop();
		cur_read(8'h11);
		set_ptr(16'h07FF);
		i_mst.start();
		wrb(C_AR, 1'b1);
		rdb(1'b0, 8'h22);
		rdb(1'b1, 8'h33);
		i_mst.stop();
		cur_read(8'h44);
		$display("test array done");
		// Refused control bytes
		foreach (BAD[i]) begin
			i_mst.start();
			wrb(BAD[i], 1'b0);
			i_mst.stop();
		end
		$display("test select done");
		// Write protection of the top 1/64
		set_ptr(16'h07DF);
		wrb(8'hAA, 1'b1);
		wrb(8'hBB, 1'b1);
		i_mst.stop();
		wr_reg(8'h00, 8'h04, 1'b1, 1'b1);
		rd_reg(8'h00, 8'h84);
		set_ptr(16'h07DF);
		wrb(8'hCC, 1'b1);
		wrb(8'hDD, 1'b0);
		wrb(8'hEE, 1'b0);
		i_mst.stop();
		cur_read(8'hBB);
		wr_reg(8'h00, 8'h03, 1'b1, 1'b1);
		rd_reg(8'h00, 8'h83);
		check({7'h00, AUTO_STORE_ENABLE}, 8'h01);
		$display("test protect done");
		// Register space commands and refusals
		wr_reg(8'h12, 8'h00, 1'b0, 1'b0);
		wr_reg(8'h55, 8'h33, 1'b1, 1'b1);
		wr_reg(8'h55, 8'hDD, 1'b1, 1'b1);
		wr_reg(8'h55, 8'h12, 1'b1, 1'b0);
		check(n_store, 8'h01);
		check(n_recall, 8'h01);
		rd_reg(8'h55, 8'h00);
		$display("test register done");
		// Store abort in mid byte keeps only acknowledged data
		set_ptr(16'h0100);
		wrb(8'h01, 1'b1);
		wrb(8'h02, 1'b1);
		i_mst.stop();
		set_ptr(16'h0100);
		wrb(8'hA1, 1'b1);
		fork
			wrb(8'hA2, 1'b0);
			begin
				repeat (150) @(posedge CLK_SYS);
				STORE_START <= 1'b1;
				@(posedge CLK_SYS) STORE_START <= 1'b0;
			end
		join
		i_mst.stop();
		set_ptr(16'h0100);
		i_mst.start();
		wrb(C_AR, 1'b1);
		rdb(1'b0, 8'hA1);
		rdb(1'b1, 8'h02);
		i_mst.stop();
		@(posedge CLK_SYS) STORE_DONE <= 1'b1;
		@(posedge CLK_SYS) STORE_DONE <= 1'b0;
		repeat (3) @(posedge CLK_SYS);
		check({7'h00, ARRAY_MODIFIED_FLAG}, 8'h00);
		$display("test abort done");
		report_and_stop();
	end
endmodule
